// *** mgt_base_div.sv ***
// Purpose: Base clock enable generator
// Assumes: Single clock, synchronous reset
// Notes: One-cycle pulse per selected base period
`timescale 1ns/1ps
`default_nettype none
module mgt_base_div
  import mgt_pkg::*;
#(
  parameter int DIV0 = MGT_DIV0,
  parameter int DIV1 = MGT_DIV1,
  parameter int DIV2 = MGT_DIV2,
  parameter int DIV3 = MGT_DIV3
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [1:0] sel_i,
  output logic tick_o
);
  typedef struct packed {
    logic [19:0] cnt;
  } mgt_div_st_t;
  mgt_div_st_t s_q, s_d;
  logic [19:0] lim;

  always_comb begin
    case (sel_i)
      2'h0: lim = 20'(DIV0 - 1);
      2'h1: lim = 20'(DIV1 - 1);
      2'h2: lim = 20'(DIV2 - 1);
      default: lim = 20'(DIV3 - 1);
    endcase
  end

  always_comb begin
    s_d = s_q;
    if (s_q.cnt >= lim) begin
      s_d.cnt = 20'h0;
    end else begin
      s_d.cnt = s_q.cnt + 20'h1;
    end
  end

  assign tick_o = (s_q.cnt >= lim);

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule : mgt_base_div
`default_nettype wire

// *** mgt_gate_src.sv ***
// Purpose: Pulse source standing on the gate pin
// Assumes: Changes only just after core clock edges
// Notes: Pin parks at a chosen idle level between pulses
`timescale 1ns/1ps
`default_nettype none
module mgt_gate_src (
  input wire logic core_clk_i,
  output logic pin_o
);
  initial pin_o = 1'b0;
  task automatic park(input logic lvl);
    @(posedge core_clk_i) pin_o <= lvl;
  endtask : park
  task automatic pulse(input logic lvl, input int w);
    @(posedge core_clk_i) pin_o <= lvl;
    repeat (w) @(posedge core_clk_i);
    pin_o <= ~lvl;
  endtask : pulse
endmodule : mgt_gate_src
`default_nettype wire

// *** mgt_pkg.sv ***
// Purpose: Constants for the modulo/gate timer counter
// Assumes: 100 MHz core clock, 4-bit register port with 16-bit transfer buffer
// Notes: Operation list follows
// Operation
// - Count selected base clock in 8-bit up-counter, compare against preloaded value.
// - Clock select 00=100kHz, 01=10kHz, 10=2kHz, 11=1kHz.
// - Control register at 2BH: select bits 1:0, clear bit 2, run bit 3.
// - Writing 1 to clear resets counter; clear bit reads 0.
// - Run bit gates base clock; gate mode also uses gate open state.
// - Counter advances only when running and, in gate mode, gate open.
// - Mode bit 0 selects modulo or external gate counting.
// - Mode bit 1 picks opening edge, bit 2 picks closing edge.
// - Gate mode raises interrupt on configured closing edge.
// - Modulo mode raises interrupt when counter equals compare value.
// - Gate mode compare match gives no interrupt.
// - Mode bit 3 flags counter overflow, which may interrupt.
// - Counter value readable through transfer buffer, not writable.
// - Compare register at 1AH via buffer, low two nibbles only.
// - Compare value all ones on power-on, watchdog, clock stop; kept on CE.
// - Control register zero on power-on, watchdog, clock stop; kept on CE.
// - Gate mode accumulates base clocks between open and close edges.
package mgt_pkg;
  localparam logic [7:0] MGT_ADDR_CMP = 8'h1A;
  localparam logic [7:0] MGT_ADDR_CTL = 8'h2B;
  localparam logic [7:0] MGT_ADDR_MODE = 8'h2C;
  localparam logic [7:0] MGT_ADDR_CNT = 8'h2D;
  localparam int MGT_CTL_SEL_LO = 0;
  localparam int MGT_CTL_CLR = 2;
  localparam int MGT_CTL_RUN = 3;
  localparam int MGT_MODE_GATE = 0;
  localparam int MGT_MODE_OPEN = 1;
  localparam int MGT_MODE_CLOSE = 2;
  localparam int MGT_MODE_OVF = 3;
  localparam logic [7:0] MGT_CMP_RST = 8'hFF;
  localparam logic [3:0] MGT_CTL_RST = 4'h0;
  localparam logic [3:0] MGT_MODE_RST = 4'h0;
  localparam int MGT_CLK_HZ = 100_000_000;
  localparam int MGT_BASE0_HZ = 100_000;
  localparam int MGT_BASE1_HZ = 10_000;
  localparam int MGT_BASE2_HZ = 2_000;
  localparam int MGT_BASE3_HZ = 1_000;
  localparam int MGT_DIV0 = MGT_CLK_HZ / MGT_BASE0_HZ;
  localparam int MGT_DIV1 = MGT_CLK_HZ / MGT_BASE1_HZ;
  localparam int MGT_DIV2 = MGT_CLK_HZ / MGT_BASE2_HZ;
  localparam int MGT_DIV3 = MGT_CLK_HZ / MGT_BASE3_HZ;
endpackage : mgt_pkg

// *** mgt_timer.sv ***
// Purpose: 8-bit modulo / external gate timer counter
// Assumes: Gate pin synchronous to core clock; register port of nibble width
// Notes: Counter and compare move through a 16-bit transfer buffer
`timescale 1ns/1ps
`default_nettype none
module mgt_timer
  import mgt_pkg::*;
#(
  parameter int DIV0 = MGT_DIV0,
  parameter int DIV1 = MGT_DIV1,
  parameter int DIV2 = MGT_DIV2,
  parameter int DIV3 = MGT_DIV3
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic watchdog_stack_reset_i,
  input wire logic clock_stop_i,
  input wire logic ce_reset_i,
  input wire logic gate_input_pin_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [3:0] reg_wdata_i,
  output logic [3:0] reg_rdata_o,
  input wire logic buf_put_i,
  input wire logic buf_get_i,
  input wire logic [15:0] transfer_buffer_i,
  output logic [15:0] transfer_buffer_o,
  output logic irq_o
);
  typedef struct packed {
    logic [7:0] cmp;
    logic [1:0] sel;
    logic run;
    logic gate;
    logic open_edge;
    logic close_edge;
    logic ovf;
    logic [7:0] cnt;
    logic gate_open;
    logic gate_prev;
    logic [15:0] buf_out;
    logic [3:0] rdata;
    logic irq;
  } mgt_st_t;

  mgt_st_t s_q, s_d;
  logic tick;
  logic hard_rst;
  logic rise, fall, open_hit, close_hit, advance, clr_wr;
  logic ovf_set;

  mgt_base_div #(
    .DIV0(DIV0),
    .DIV1(DIV1),
    .DIV2(DIV2),
    .DIV3(DIV3)
  ) u_div (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .sel_i(s_q.sel),
    .tick_o(tick)
  );

  // Edge of chosen polarity
  function automatic logic edge_hit(input logic want_rise, input logic r, input logic f);
    edge_hit = want_rise ? r : f;
  endfunction : edge_hit

  assign hard_rst = watchdog_stack_reset_i | clock_stop_i;
  assign rise = gate_input_pin_i & ~s_q.gate_prev;
  assign fall = ~gate_input_pin_i & s_q.gate_prev;
  assign open_hit = edge_hit(s_q.open_edge, rise, fall);
  assign close_hit = edge_hit(s_q.close_edge, rise, fall);
  assign advance = tick & s_q.run & (~s_q.gate | s_q.gate_open);
  assign clr_wr = reg_wr_i && reg_addr_i == MGT_ADDR_CTL && reg_wdata_i[MGT_CTL_CLR];
  assign ovf_set = advance && s_q.cnt == 8'hFF && (s_q.gate || s_q.cnt != s_q.cmp);

  always_comb begin
    s_d = s_q;
    s_d.irq = 1'b0;
    s_d.gate_prev = gate_input_pin_i;
    if (s_q.gate) begin
      if (s_q.gate_open && close_hit) begin
        s_d.gate_open = 1'b0;
        s_d.irq = 1'b1;
      end else if (!s_q.gate_open && open_hit) begin
        s_d.gate_open = 1'b1;
      end
    end else begin
      s_d.gate_open = 1'b0;
    end
    if (advance) begin
      if (!s_q.gate && s_q.cnt == s_q.cmp) begin
        s_d.cnt = 8'h0;
      end else begin
        s_d.cnt = s_q.cnt + 8'h1;
        if (s_q.cnt == 8'hFF) begin
          s_d.ovf = 1'b1;
          s_d.irq = 1'b1;
        end
      end
      if (!s_q.gate && s_q.cnt != s_q.cmp && s_q.cnt + 8'h1 == s_q.cmp) begin
        s_d.irq = 1'b1;
      end
    end
    if (reg_wr_i) begin
      case (reg_addr_i)
        MGT_ADDR_CTL: begin
          s_d.sel = reg_wdata_i[MGT_CTL_SEL_LO +: 2];
          s_d.run = reg_wdata_i[MGT_CTL_RUN];
        end
        MGT_ADDR_MODE: begin
          s_d.gate = reg_wdata_i[MGT_MODE_GATE];
          s_d.open_edge = reg_wdata_i[MGT_MODE_OPEN];
          s_d.close_edge = reg_wdata_i[MGT_MODE_CLOSE];
          if (!reg_wdata_i[MGT_MODE_OVF] && !ovf_set) begin
            s_d.ovf = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    if (clr_wr) begin
      s_d.cnt = 8'h0;
    end
    // compare through buffer, low byte only
    if (buf_put_i && reg_addr_i == MGT_ADDR_CMP) begin
      s_d.cmp = transfer_buffer_i[7:0];
    end
    if (buf_get_i) begin
      case (reg_addr_i)
        MGT_ADDR_CMP: s_d.buf_out = {8'h00, s_q.cmp};
        MGT_ADDR_CNT: s_d.buf_out = {8'h00, s_q.cnt};
        default: s_d.buf_out = 16'h0000;
      endcase
    end
    case (reg_addr_i)
      MGT_ADDR_CTL: s_d.rdata = {s_q.run, 1'b0, s_q.sel};
      MGT_ADDR_MODE: s_d.rdata = {s_q.ovf, s_q.close_edge, s_q.open_edge, s_q.gate};
      default: s_d.rdata = 4'h0;
    endcase
  end

  assign reg_rdata_o = s_q.rdata;
  assign transfer_buffer_o = s_q.buf_out;
  assign irq_o = s_q.irq;

  always_ff @(posedge core_clk_i) begin
    if (rst_i || hard_rst) begin
      s_q.cmp <= MGT_CMP_RST;
      {s_q.run, s_q.sel} <= 3'(MGT_CTL_RST);
      {s_q.ovf, s_q.close_edge, s_q.open_edge, s_q.gate} <= MGT_MODE_RST;
      s_q.cnt <= 8'h00;
      s_q.gate_open <= 1'b0;
      s_q.gate_prev <= 1'b0;
      s_q.buf_out <= 16'h0000;
      s_q.rdata <= 4'h0;
      s_q.irq <= 1'b0;
    end else if (ce_reset_i) begin
      // CE reset keeps compare and control
      s_q.irq <= 1'b0;
      s_q.gate_prev <= gate_input_pin_i;
    end else begin
      s_q <= s_d;
    end
  end

  property p_clear_zero;
    @(posedge core_clk_i) disable iff (rst_i || hard_rst || ce_reset_i)
      clr_wr |=> s_q.cnt == 8'h00;
  endproperty
  a_clear_zero: assert property (p_clear_zero) else $error("counter not cleared");

  property p_hold_stopped;
    @(posedge core_clk_i) disable iff (rst_i || hard_rst || ce_reset_i)
      (!s_q.run && !clr_wr) |=> s_q.cnt == $past(s_q.cnt);
  endproperty
  a_hold_stopped: assert property (p_hold_stopped) else $error("counter moved while stopped");

  // no match irq in gate mode without close or wrap
  property p_gate_no_match;
    @(posedge core_clk_i) disable iff (rst_i || hard_rst || ce_reset_i)
      (s_q.gate && !close_hit && !(advance && s_q.cnt == 8'hFF)) |=> !irq_o;
  endproperty
  a_gate_no_match: assert property (p_gate_no_match) else $error("gate mode spurious irq");

  property p_close_irq;
    @(posedge core_clk_i) disable iff (rst_i || hard_rst || ce_reset_i)
      (s_q.gate && s_q.gate_open && close_hit) |=> irq_o && !s_q.gate_open;
  endproperty
  a_close_irq: assert property (p_close_irq) else $error("close edge missed");

  property p_modulo_wrap;
    @(posedge core_clk_i) disable iff (rst_i || hard_rst || ce_reset_i)
      (advance && !s_q.gate && s_q.cnt == s_q.cmp) |=> s_q.cnt == 8'h00;
  endproperty
  a_modulo_wrap: assert property (p_modulo_wrap) else $error("modulo restart missed");

  property p_wrap_ovf;
    @(posedge core_clk_i) disable iff (rst_i || hard_rst || ce_reset_i)
      (advance && s_q.cnt == 8'hFF && !(s_q.cmp == 8'hFF && !s_q.gate)) |=> s_q.ovf && irq_o;
  endproperty
  a_wrap_ovf: assert property (p_wrap_ovf) else $error("overflow flag not set");

  property p_cmp_reset;
    @(posedge core_clk_i) hard_rst |=> s_q.cmp == MGT_CMP_RST && s_q.run == 1'b0;
  endproperty
  a_cmp_reset: assert property (p_cmp_reset) else $error("compare not reset");

  property p_ce_keep;
    @(posedge core_clk_i) disable iff (rst_i || hard_rst)
      ce_reset_i |=> s_q.sel == $past(s_q.sel) && s_q.cmp == $past(s_q.cmp);
  endproperty
  a_ce_keep: assert property (p_ce_keep) else $error("CE reset changed state");

  property p_match_irq;
    @(posedge core_clk_i) disable iff (rst_i || hard_rst || ce_reset_i)
      (advance && !s_q.gate && s_q.cnt != s_q.cmp && s_q.cnt + 8'h1 == s_q.cmp) |=> irq_o;
  endproperty
  a_match_irq: assert property (p_match_irq) else $error("match irq missed");

  property p_ovf_sticky;
    @(posedge core_clk_i) disable iff (rst_i || hard_rst || ce_reset_i)
      (s_q.ovf && !(reg_wr_i && reg_addr_i == MGT_ADDR_MODE && !reg_wdata_i[MGT_MODE_OVF])) |=> s_q.ovf;
  endproperty
  a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow flag lost");

  property p_stop_quiet;
    @(posedge core_clk_i) disable iff (rst_i || hard_rst || ce_reset_i)
      (!s_q.run && !(s_q.gate && s_q.gate_open && close_hit)) |=> !irq_o;
  endproperty
  a_stop_quiet: assert property (p_stop_quiet) else $error("irq while stopped");

  property p_gate_hold;
    @(posedge core_clk_i) disable iff (rst_i || hard_rst || ce_reset_i)
      (s_q.gate && !s_q.gate_open && !clr_wr) |=> s_q.cnt == $past(s_q.cnt);
  endproperty
  a_gate_hold: assert property (p_gate_hold) else $error("count moved with gate closed");

  property p_count_step;
    @(posedge core_clk_i) disable iff (rst_i || hard_rst || ce_reset_i)
      (advance && !clr_wr && (s_q.gate || s_q.cnt != s_q.cmp)) |=> s_q.cnt == $past(s_q.cnt) + 8'h1;
  endproperty
  a_count_step: assert property (p_count_step) else $error("count step wrong");

  property p_gate_open;
    @(posedge core_clk_i) disable iff (rst_i || hard_rst || ce_reset_i)
      (s_q.gate && !s_q.gate_open && open_hit) |=> s_q.gate_open;
  endproperty
  a_gate_open: assert property (p_gate_open) else $error("gate did not open");

  property p_cmp_load;
    @(posedge core_clk_i) disable iff (rst_i || hard_rst || ce_reset_i)
      (buf_put_i && reg_addr_i == MGT_ADDR_CMP) |=> s_q.cmp == $past(transfer_buffer_i[7:0]);
  endproperty
  a_cmp_load: assert property (p_cmp_load) else $error("compare load wrong");

  property p_cnt_read;
    @(posedge core_clk_i) disable iff (rst_i || hard_rst || ce_reset_i)
      (buf_get_i && reg_addr_i == MGT_ADDR_CNT) |=> transfer_buffer_o == {8'h00, $past(s_q.cnt)};
  endproperty
  a_cnt_read: assert property (p_cnt_read) else $error("count read wrong");

  property p_ctl_write;
    @(posedge core_clk_i) disable iff (rst_i || hard_rst || ce_reset_i)
      (reg_wr_i && reg_addr_i == MGT_ADDR_CTL) |=> s_q.run == $past(reg_wdata_i[MGT_CTL_RUN]) &&
        s_q.sel == $past(reg_wdata_i[MGT_CTL_SEL_LO +: 2]);
  endproperty
  a_ctl_write: assert property (p_ctl_write) else $error("control write lost");
endmodule : mgt_timer
`default_nettype wire

// *** mgt_timer_test.sv ***
// Purpose: Self-checking bench for the timer counter
// Assumes: Short base dividers 2,3,4,5
// Notes: Irq pulses are counted over fixed windows
`timescale 1ns/1ps
`default_nettype none
module mgt_timer_test;
  import mgt_pkg::*;
  logic clk = 1'b0, rst = 1'b1, wd = 1'b0, cs = 1'b0, ce = 1'b0;
  logic wr = 1'b0, put = 1'b0, get = 1'b0, gate, irq;
  logic [7:0] addr = 8'h00;
  logic [3:0] wdata = 4'h0, rdata;
  logic [15:0] bufi = 16'h0000, bufo, v, w;
  int bad_count = 0, tests_run = 0, irq_cnt = 0, cyc = 0, n0;
  always #5 clk = ~clk;
  mgt_gate_src src (.core_clk_i(clk), .pin_o(gate));
  mgt_timer #(.DIV0(2), .DIV1(3), .DIV2(4), .DIV3(5)) dut (.core_clk_i(clk), .rst_i(rst),
    .watchdog_stack_reset_i(wd), .clock_stop_i(cs), .ce_reset_i(ce), .gate_input_pin_i(gate),
    .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .buf_put_i(put),
    .buf_get_i(get), .transfer_buffer_i(bufi), .transfer_buffer_o(bufo), .irq_o(irq));
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
    if (cyc == 20000) begin
      bad_count++;
      close_out();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wreg(input logic [7:0] a, input logic [3:0] d);
    @(posedge clk) begin addr <= a; wdata <= d; wr <= 1'b1; end
    @(posedge clk) wr <= 1'b0;
  endtask : wreg
  task automatic rd(input logic [7:0] a, input logic [3:0] e);
    @(posedge clk) addr <= a;
    repeat (2) @(posedge clk);
    #1 chk({12'h000, rdata}, {12'h000, e});
  endtask : rd
  task automatic bput(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk) begin addr <= a; bufi <= d; put <= 1'b1; end
    @(posedge clk) put <= 1'b0;
  endtask : bput
  task automatic bget(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk) begin addr <= a; get <= 1'b1; end
    @(posedge clk) get <= 1'b0;
    @(posedge clk);
    #1 d = bufo;
  endtask : bget
  task automatic t_regs();
    rd(MGT_ADDR_CTL, MGT_CTL_RST);
    rd(MGT_ADDR_MODE, MGT_MODE_RST);
    bget(MGT_ADDR_CMP, v);
    chk(v, 16'h00FF);
    wreg(MGT_ADDR_CTL, 4'h7);
    rd(MGT_ADDR_CTL, 4'h3);
    wreg(8'h3F, 4'hF);
    rd(MGT_ADDR_CTL, 4'h3);
    bput(MGT_ADDR_CMP, 16'hAB5C);
    bget(MGT_ADDR_CMP, v);
    chk(v, 16'h005C);
    @(posedge clk) ce <= 1'b1;
    @(posedge clk) ce <= 1'b0;
    rd(MGT_ADDR_CTL, 4'h3);
    bget(MGT_ADDR_CMP, v);
    chk(v, 16'h005C);
    @(posedge clk) wd <= 1'b1;
    @(posedge clk) wd <= 1'b0;
    rd(MGT_ADDR_CTL, 4'h0);
    bget(MGT_ADDR_CMP, v);
    chk(v, 16'h00FF);
    wreg(MGT_ADDR_CTL, 4'hB);
    bput(MGT_ADDR_CMP, 16'h0012);
    @(posedge clk) cs <= 1'b1;
    @(posedge clk) cs <= 1'b0;
    rd(MGT_ADDR_CTL, 4'h0);
    bget(MGT_ADDR_CMP, v);
    chk(v, 16'h00FF);
  endtask : t_regs
  task automatic t_stop();
    wreg(MGT_ADDR_CTL, 4'h8);
    repeat (20) @(posedge clk);
    wreg(MGT_ADDR_CTL, 4'h0);
    bget(MGT_ADDR_CNT, v);
    repeat (20) @(posedge clk);
    bget(MGT_ADDR_CNT, w);
    chk(w, v);
    chk({15'h0000, v != 16'h0000}, 16'h0001);
    bput(MGT_ADDR_CNT, 16'h0055);
    bget(MGT_ADDR_CNT, w);
    chk(w, v);
    wreg(MGT_ADDR_CTL, 4'h4);
    bget(MGT_ADDR_CNT, v);
    chk(v, 16'h0000);
  endtask : t_stop
  task automatic t_modulo();
    bput(MGT_ADDR_CMP, 16'h0003);
    for (int s = 0; s < 4; s++) begin
      wreg(MGT_ADDR_CTL, 4'h4);
      wreg(MGT_ADDR_CTL, 4'h8 | 4'(s));
      repeat (30) @(posedge clk);
      n0 = irq_cnt;
      repeat (240) @(posedge clk);
      chk(16'(irq_cnt - n0), 16'(240 / (4 * (s + 2))));
    end
    wreg(MGT_ADDR_CTL, 4'h0);
  endtask : t_modulo
  // sticky overflow with gate held open
  task automatic t_ovf();
    src.park(1'b0);
    wreg(MGT_ADDR_MODE, 4'h3);
    wreg(MGT_ADDR_CTL, 4'h4);
    wreg(MGT_ADDR_CTL, 4'h8);
    n0 = irq_cnt;
    src.park(1'b1);
    repeat (560) @(posedge clk);
    chk(16'(irq_cnt - n0), 16'h0001);
    src.park(1'b0);
    wreg(MGT_ADDR_CTL, 4'h0);
    rd(MGT_ADDR_MODE, 4'hB);
    wreg(MGT_ADDR_MODE, 4'h0);
    rd(MGT_ADDR_MODE, 4'h0);
  endtask : t_ovf
  // pulse width in both edge setups
  task automatic t_gate(input logic lvl, input logic [3:0] md);
    wreg(MGT_ADDR_MODE, 4'h0);
    src.park(~lvl);
    wreg(MGT_ADDR_MODE, md);
    bput(MGT_ADDR_CMP, 16'h0002);
    wreg(MGT_ADDR_CTL, 4'h4);
    wreg(MGT_ADDR_CTL, 4'h8);
    repeat (10) @(posedge clk);
    n0 = irq_cnt;
    src.pulse(lvl, 20);
    repeat (4) @(posedge clk);
    chk(16'(irq_cnt - n0), 16'h0001);
    bget(MGT_ADDR_CNT, v);
    chk({15'h0000, v >= 16'h0009 && v <= 16'h000B}, 16'h0001);
    repeat (20) @(posedge clk);
    bget(MGT_ADDR_CNT, w);
    chk(w, v);
    wreg(MGT_ADDR_CTL, 4'h0);
  endtask : t_gate
  task automatic close_out();
    $display("Checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_stop();
    t_modulo();
    t_ovf();
    t_gate(1'b1, 4'h3);
    t_gate(1'b0, 4'h5);
    close_out();
  end
endmodule : mgt_timer_test
`default_nettype wire
